/* File: ntbrt_consts.svh */
// Purpose: offsets, field positions and masks of the routing block
// Assumes: 12-bit byte address on the configuration port
// Notes:   definitions only, included by the top alone
`ifndef NTBRT_CONSTS_SVH
`define NTBRT_CONSTS_SVH

// documented configuration words
`define NTBRT_OFS_CMD    12'h004
`define NTBRT_OFS_BUS    12'h018
`define NTBRT_OFS_MEM    12'h020
`define NTBRT_OFS_PF     12'h024
// window and lookup pages selected by upper address bits, own window and status words
`define NTBRT_PG_SETUP   8'h10
`define NTBRT_PG_XLAT    8'h11
`define NTBRT_PG_WBASE   8'h12
`define NTBRT_OFS_SWBAR  12'h130
`define NTBRT_OFS_STAT   12'h134
`define NTBRT_PG_LUT     5'h04

// command word bits
`define NTBRT_CMD_IO     0
`define NTBRT_CMD_MEM    1
`define NTBRT_CMD_BME    2
// window size config fields
`define NTBRT_SETUP_PF   3
`define NTBRT_SETUP_TYPE 2:1
`define NTBRT_TYPE_64    2'b10
`define NTBRT_SIZE_MASK  32'hFFF0_0000
// base/limit granule of the bridge windows
`define NTBRT_BL_LOW     20'h0_0000
`define NTBRT_BL_HIGH    20'hF_FFFF
// switch own window: 256 KB, bit 0 enables it
`define NTBRT_SWBAR_MASK 32'hFFFC_0000
`define NTBRT_SWBAR_EN   0
// lookup entry: enable bit, bus/device in [15:3]
`define NTBRT_LUT_EN     31
`define NTBRT_LUT_N      32
`define NTBRT_WIN_N      4

`endif

/* File: ntbrt_pkg.sv */
// Purpose: packet kinds and routing outcomes of the routing block
// Assumes: nothing beyond SystemVerilog enums
// Notes:   outcome codes are left to the tool
package ntbrt_pkg;

   // packet classes seen by the router
   typedef enum logic [1:0] {
      NTBRT_KIND_MEM,
      NTBRT_KIND_IO,
      NTBRT_KIND_CPL,
      NTBRT_KIND_CFG
   } ntbrt_kind_t;

   // where a packet goes
   typedef enum logic [2:0] {
      NTBRT_TO_UP,
      NTBRT_TO_DOWN,
      NTBRT_TO_SELF,
      NTBRT_TO_CROSS,
      NTBRT_TO_UR,
      NTBRT_TO_UNEXP
   } ntbrt_dest_t;

endpackage

/* File: ntbrt_sink.sv */
// Purpose: consumer of routing decisions at the far side of the block
// Assumes: a decision is taken on an edge with outValid and outReady
// Notes:   slow mode takes one decision in three cycles
`timescale 1ns/1ns
module ntbrt_sink (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic slow,
   input  wire logic outValid,
   output logic      outReady
);
   logic [1:0] phaseQ; // stall pattern counter

   // ready moves just after the edge, never on the sampling edge itself
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         phaseQ   <= #1 2'h0;
         outReady <= #1 1'b0;
      end else begin
         // a real consumer stalls: hold decisions back two cycles of three
         phaseQ   <= #1 (phaseQ == 2'h2) ? 2'h0 : phaseQ + 2'h1;
         outReady <= #1 !slow || (phaseQ == 2'h1);
      end
   end
endmodule

/* File: ntbrt_top.sv */
// Purpose: routing, address and requester id translation of a
//          domain isolating port
// Assumes: packet header fields arrive pre-parsed on the clock
// Notes:   one decision per accepted header, one cycle latency
`timescale 1ns/1ns
`include "ntbrt_consts.svh"

// Behaviour
// - address within base/limit goes downstream
// - bus within secondary..subordinate goes downstream
// - memory hitting own window claimed by switch
// - bus equal to internal bridge bus claimed
// - everything else goes upstream
// - windows two-five at port cross domains
// - 64-bit window joins pair two-three/four-five
// - endpoint device number equals port number
// - internal bus number taken from bus word
// - each window owns its translation value
// - requester id is bus, device, low
// - requester without enabled entry is blocked
// - outgoing packets carry lookup entry index
// - setup value splits base from offset
// - base bits replaced, offset bits kept
// - either domain may be 32 or 64 bit
// - setup bits 31:20 set claim 1 MB
// - 32-entry table, miss or disabled gives UR
// - index replaces device, port bus replaces bus
// - completion restored by index, else unexpected
// - setup bit 3 prefetch, bits 2:1 width
module ntbrt_top #(
   parameter logic [4:0] PORT_NUM = 5'h00
) (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic                  cfgWe,
   input  wire logic                  cfgRe,
   input  wire logic [11:0]           cfgAddr,
   input  wire logic [31:0]           cfgWdata,
   output logic      [31:0]           cfgRdata,
   input  wire logic                  tlpValid,
   output logic                       tlpReady,
   input  wire ntbrt_pkg::ntbrt_kind_t tlpKind,
   input  wire logic                  tlpAtPort,
   input  wire logic [63:0]           tlpAddr,
   input  wire logic [7:0]            tlpBus,
   input  wire logic [15:0]           tlpReqId,
   output logic                       outValid,
   input  wire logic                  outReady,
   output ntbrt_pkg::ntbrt_dest_t     outDest,
   output logic      [63:0]           outAddr,
   output logic                       outIs64,
   output logic      [15:0]           outReqId,
   output logic      [15:0]           outCplId,
   output logic      [4:0]            outIdx
);
   import ntbrt_pkg::*;

   localparam int WN = `NTBRT_WIN_N;  // windows two through five
   localparam int LN = `NTBRT_LUT_N;  // lookup entries per direction

   logic [31:0] cmd_q;           // command word
   logic [31:0] bus_q;           // primary/secondary/subordinate
   logic [31:0] mem_q;           // memory base/limit
   logic [31:0] pf_q;            // prefetchable base/limit
   logic [31:0] swBar_q;         // switch own window base
   logic [31:0] setup_q [WN];    // window size config
   logic [31:0] xlat_q  [WN];    // window translation value
   logic [31:0] wbase_q [WN];    // window base as enumerated
   logic [12:0] lutRid_q [LN];   // stored bus and device
   logic [LN-1:0] lutEn_q;       // entry enables
   logic [7:0]  stat_q;          // last index and outcome
   logic [31:0] rd_d;            // read mux

   logic        take;            // header accepted this cycle
   logic [7:0]  priBus, secBus, subBus;

   assign priBus = bus_q[7:0];
   assign secBus = bus_q[15:8];   // internal virtual bus
   assign subBus = bus_q[23:16];

   // handshake: one stage, refill while draining
   assign tlpReady = !outValid || outReady;
   assign take     = ce && tlpValid && tlpReady;

   // configuration writes; tables are expected quiet when changed
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmd_q   <= '0;
         bus_q   <= '0;
         mem_q   <= '0;
         pf_q    <= '0;
         swBar_q <= '0;
         lutEn_q <= '0;
         for (int i = 0; i < WN; i++) begin
            setup_q[i] <= '0;
            xlat_q[i]  <= '0;
            wbase_q[i] <= '0;
         end
         for (int i = 0; i < LN; i++) begin
            lutRid_q[i] <= '0;
         end
      end else if (ce && cfgWe) begin
         case (cfgAddr)
            `NTBRT_OFS_CMD:   cmd_q   <= cfgWdata;
            `NTBRT_OFS_BUS:   bus_q   <= cfgWdata;
            `NTBRT_OFS_MEM:   mem_q   <= cfgWdata;
            `NTBRT_OFS_PF:    pf_q    <= cfgWdata;
            `NTBRT_OFS_SWBAR: swBar_q <= cfgWdata;
            default: ;
         endcase
         // bit 0 is forced low on the lower half of a pair; the upper half keeps every bit
         if (cfgAddr[11:4] == `NTBRT_PG_SETUP) begin
            setup_q[cfgAddr[3:2]] <= cfgAddr[2] ?
               cfgWdata : (cfgWdata & ~32'h0000_0001);
         end
         if (cfgAddr[11:4] == `NTBRT_PG_XLAT) begin
            xlat_q[cfgAddr[3:2]] <= cfgWdata;
         end
         if (cfgAddr[11:4] == `NTBRT_PG_WBASE) begin
            wbase_q[cfgAddr[3:2]] <= cfgWdata;
         end
         if (cfgAddr[11:7] == `NTBRT_PG_LUT) begin
            lutRid_q[cfgAddr[6:2]] <= cfgWdata[15:3];
            lutEn_q[cfgAddr[6:2]]  <= cfgWdata[`NTBRT_LUT_EN];
         end
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_d = '0;
      case (cfgAddr)
         `NTBRT_OFS_CMD:   rd_d = cmd_q;
         `NTBRT_OFS_BUS:   rd_d = bus_q;
         `NTBRT_OFS_MEM:   rd_d = mem_q;
         `NTBRT_OFS_PF:    rd_d = pf_q;
         `NTBRT_OFS_SWBAR: rd_d = swBar_q;
         `NTBRT_OFS_STAT:  rd_d = {24'h00_0000, stat_q};
         default: ;
      endcase
      if (cfgAddr[11:4] == `NTBRT_PG_SETUP) begin
         rd_d = setup_q[cfgAddr[3:2]];
      end
      if (cfgAddr[11:4] == `NTBRT_PG_XLAT) begin
         rd_d = xlat_q[cfgAddr[3:2]];
      end
      if (cfgAddr[11:4] == `NTBRT_PG_WBASE) begin
         rd_d = wbase_q[cfgAddr[3:2]];
      end
      if (cfgAddr[11:7] == `NTBRT_PG_LUT) begin
         rd_d = {lutEn_q[cfgAddr[6:2]], 15'h0000,
                 lutRid_q[cfgAddr[6:2]], 3'h0};
      end
   end

   // read data registered, valid the cycle after cfgRe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfgRdata <= '0;
      end else if (ce && cfgRe) begin
         cfgRdata <= rd_d;
      end
   end

   // per-window hit and direct translation
   logic [WN-1:0] winHit;
   logic [63:0]   winOut [WN];
   for (genvar w = 0; w < WN; w++) begin : gWin
      localparam int U = (w % 2 == 0) ? w + 1 : w;  // upper partner
      localparam int L = (w % 2 == 1) ? w - 1 : w;  // lower partner
      logic        pair, upperHalf, en;
      logic [31:0] mLo, mHi, bHi;
      // 64-bit only when the lower half says so
      assign pair = (w % 2 == 0) &&
         (setup_q[w][`NTBRT_SETUP_TYPE] == `NTBRT_TYPE_64);
      assign upperHalf = (w % 2 == 1) &&
         (setup_q[L][`NTBRT_SETUP_TYPE] == `NTBRT_TYPE_64);
      // size bits form the base mask
      assign mLo = setup_q[w] & `NTBRT_SIZE_MASK;
      assign mHi = pair ? setup_q[U] : 32'hFFFF_FFFF;
      assign bHi = pair ? wbase_q[U] : 32'h0000_0000;
      assign en  = (|mLo) && !upperHalf;
      assign winHit[w] = en &&
         (((tlpAddr[31:0] ^ wbase_q[w]) & mLo) == 32'h0000_0000) &&
         (((tlpAddr[63:32] ^ bHi) & mHi) == 32'h0000_0000);
      // base swapped under mask, offset kept
      assign winOut[w][31:0] = (tlpAddr[31:0] & ~mLo) |
                               (xlat_q[w] & mLo);
      // 32-bit window lands low, a pair may land high
      assign winOut[w][63:32] = pair ?
         ((tlpAddr[63:32] & ~mHi) | (xlat_q[U] & mHi)) : 32'h0000_0000;
   end

   logic        winAny;      // some window claims the address
   logic [63:0] selAddr;     // translated address of first hit
   logic        lutHit;      // requester found in table
   logic [4:0]  lutIdx;      // its entry index
   logic        lutOk;       // found and enabled

   // lowest window wins; lowest matching entry wins
   always_comb begin
      winAny  = 1'b0;
      selAddr = '0;
      for (int w = 0; w < WN; w++) begin
         if (winHit[w] && !winAny) begin
            winAny  = 1'b1;
            selAddr = winOut[w];
         end
      end
      lutHit = 1'b0;
      lutIdx = '0;
      // function bits take no part in the match
      for (int i = 0; i < LN; i++) begin
         if (!lutHit && lutRid_q[i] == tlpReqId[15:3]) begin
            lutHit = 1'b1;
            lutIdx = 5'(i);
         end
      end
      lutOk = lutHit && lutEn_q[lutIdx];
   end

   // bridge window and bus compares for normal routing
   logic inMem, inPf, swHit, busSelf, busDown, addrDown;
   assign inMem = (tlpAddr[63:32] == 32'h0000_0000) &&
      (tlpAddr[31:0] >= {mem_q[15:4], `NTBRT_BL_LOW}) &&
      (tlpAddr[31:0] <= {mem_q[31:20], `NTBRT_BL_HIGH});
   assign inPf = (tlpAddr[63:32] == 32'h0000_0000) &&
      (tlpAddr[31:0] >= {pf_q[15:4], `NTBRT_BL_LOW}) &&
      (tlpAddr[31:0] <= {pf_q[31:20], `NTBRT_BL_HIGH});
   assign swHit = swBar_q[`NTBRT_SWBAR_EN] && cmd_q[`NTBRT_CMD_MEM] &&
      (tlpAddr[63:32] == 32'h0000_0000) &&
      (((tlpAddr[31:0] ^ swBar_q) & `NTBRT_SWBAR_MASK) == 32'h0);
   assign busSelf = (tlpBus == priBus) || (tlpBus == secBus);
   assign busDown = (tlpBus >= secBus) && (tlpBus <= subBus);
   // io shares the memory window; command bits gate forwarding
   assign addrDown = (tlpKind == NTBRT_KIND_MEM) ?
      (cmd_q[`NTBRT_CMD_MEM] && (inMem || inPf)) :
      ((tlpKind == NTBRT_KIND_IO) && cmd_q[`NTBRT_CMD_IO] && inMem);

   ntbrt_dest_t dDest;
   logic [63:0] dAddr;
   logic [15:0] dRid, dCpl;
   logic [4:0]  dIdx;

   // routing decision for the header on the input
   always_comb begin
      dDest = NTBRT_TO_UP;
      dAddr = tlpAddr;
      dRid  = tlpReqId;
      dCpl  = '0;
      dIdx  = '0;
      if (tlpAtPort) begin
         dDest = NTBRT_TO_UR;
         if (tlpKind == NTBRT_KIND_MEM) begin
            // crossing needs a window and a registered requester
            if (winAny && cmd_q[`NTBRT_CMD_BME] && lutOk) begin
               dDest = NTBRT_TO_CROSS;
               dAddr = selAddr;
               dRid  = {secBus, lutIdx, tlpReqId[2:0]};
               dIdx  = lutIdx;
            end
         end else if (tlpKind == NTBRT_KIND_CPL) begin
            dIdx = tlpReqId[7:3];
            if (lutEn_q[dIdx]) begin
               dDest = NTBRT_TO_CROSS;
               dRid  = {lutRid_q[dIdx], tlpReqId[2:0]};
               dCpl  = {secBus, PORT_NUM, 3'h0};
            end else begin
               dDest = NTBRT_TO_UNEXP;
            end
         end
      end else if (tlpKind == NTBRT_KIND_CPL ||
                   tlpKind == NTBRT_KIND_CFG) begin
         // exact bus match beats the downstream range
         if (busSelf) begin
            dDest = NTBRT_TO_SELF;
         end else if (busDown) begin
            dDest = NTBRT_TO_DOWN;
         end
      end else if (tlpKind == NTBRT_KIND_MEM && swHit) begin
         dDest = NTBRT_TO_SELF;
      end else if (addrDown) begin
         dDest = NTBRT_TO_DOWN;
      end
   end

   // output stage holds until drained
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         outValid <= 1'b0;
         outDest  <= NTBRT_TO_UP;
         outAddr  <= '0;
         outIs64  <= 1'b0;
         outReqId <= '0;
         outCplId <= '0;
         outIdx   <= '0;
      end else if (ce) begin
         if (take) begin
            outValid <= 1'b1;
            outDest  <= dDest;
            outAddr  <= dAddr;
            outIs64  <= |dAddr[63:32];
            outReqId <= dRid;
            outCplId <= dCpl;
            outIdx   <= dIdx;
         end else if (outReady) begin
            outValid <= 1'b0;
         end
      end
   end

   // last outcome, readable for debug of blocked requesters
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stat_q <= '0;
      end else if (take) begin
         stat_q <= {dIdx, dDest};
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence sTake;
      take && !tlpAtPort;
   endsequence
   sequence sPortMem;
      take && tlpAtPort && tlpKind == NTBRT_KIND_MEM;
   endsequence

   down_mem_a: assert property (sTake ##0 (tlpKind == NTBRT_KIND_MEM
      && !swHit && cmd_q[`NTBRT_CMD_MEM] && inMem)
      |=> outDest == NTBRT_TO_DOWN)
      else $error("memory in window not sent down");
   bus_range_a: assert property (sTake ##0 (tlpKind == NTBRT_KIND_CFG
      && !busSelf && tlpBus > secBus && tlpBus <= subBus)
      |=> outDest == NTBRT_TO_DOWN)
      else $error("bus in range not sent down");
   self_bar_a: assert property (sTake ##0 (tlpKind == NTBRT_KIND_MEM
      && swHit) |=> outDest == NTBRT_TO_SELF)
      else $error("own window not claimed");
   self_bus_a: assert property (sTake ##0 (tlpKind == NTBRT_KIND_CPL
      && tlpBus == priBus) |=> outDest == NTBRT_TO_SELF)
      else $error("own bus not claimed");
   up_default_a: assert property (sTake ##0 (tlpKind == NTBRT_KIND_MEM
      && !swHit && !inMem && !inPf)
      |=> outDest == NTBRT_TO_UP)
      else $error("unclaimed packet not sent up");
   cross_offset_a: assert property (sPortMem ##0 (winAny && lutOk
      && cmd_q[`NTBRT_CMD_BME]) |=> outDest == NTBRT_TO_CROSS
      && outAddr[19:0] == $past(tlpAddr[19:0]))
      else $error("crossing lost offset bits");
   lut_block_a: assert property (sPortMem ##0 !lutOk
      |=> outDest == NTBRT_TO_UR)
      else $error("unregistered requester crossed");
   rid_swap_a: assert property (sPortMem ##0 (winAny && lutOk
      && cmd_q[`NTBRT_CMD_BME]) |=> outReqId[7:3] == outIdx
      && outReqId[15:8] == $past(secBus)
      && outReqId[2:0] == $past(tlpReqId[2:0]))
      else $error("requester id not rewritten");
   cpl_restore_a: assert property (take && tlpAtPort
      && tlpKind == NTBRT_KIND_CPL && !lutEn_q[tlpReqId[7:3]]
      |=> outDest == NTBRT_TO_UNEXP)
      else $error("invalid entry completion forwarded");
   hold_out_a: assert property (outValid && !outReady
      |=> outValid && $stable(outAddr) && $stable(outDest))
      else $error("output dropped while stalled");
   off_win_a: assert property (winAny |-> (|(winHit &
      {|setup_q[3][31:20], |setup_q[2][31:20],
       |setup_q[1][31:20], |setup_q[0][31:20]})))
      else $error("disabled window claimed");

endmodule

/* File: ntbrt_top_tb.sv */
// Purpose: self-checking bench of the routing and translation block
// Assumes: one decision per header, read data one cycle after the read
// Notes:   driver queues expectations, a monitor compares them
`timescale 1ns/1ns
module ntbrt_top_tb;
   import ntbrt_pkg::*;
   typedef struct {
      ntbrt_dest_t dest; // expected destination
      logic        full; // low: destination only
      logic [63:0] addr;
      logic [15:0] rid;
      logic [4:0]  idx;
      logic [15:0] cid;
   } ntbrt_exp_t;
   logic        clock = 1'b0;
   logic        rst, ce, cfgWe, cfgRe, tlpValid, tlpAtPort, slow, rdSeen;
   logic        outValid, tlpReady, outReady, outIs64;
   logic [11:0] cfgAddr;
   logic [31:0] cfgWdata, cfgRdata;
   logic [63:0] tlpAddr, outAddr;
   logic [7:0]  tlpBus;
   logic [15:0] tlpReqId, outReqId, outCplId;
   logic [4:0]  outIdx;
   ntbrt_kind_t tlpKind;
   ntbrt_dest_t outDest;
   int          errors = 0, testsRun = 0;
   ntbrt_exp_t  expQ[$]; // pending decisions
   logic [31:0] rdQ[$];  // pending read data
   // setup: bridge words, windows 2..5, own window, lookup entries
   logic [11:0] wa[17] = '{12'h004, 12'h018, 12'h020, 12'h130, 12'h100,
      12'h110, 12'h120, 12'h124, 12'h108, 12'h10C, 12'h118, 12'h11C,
      12'h128, 12'h12C, 12'h208, 12'h20C, 12'h300};
   logic [31:0] wd[17] = '{32'h0000_0007, 32'h0005_0201, 32'h80F0_8000,
      32'h9000_0001, 32'hFFF0_0000, 32'h2750_0000, 32'h5F00_0000,
      32'h6000_0000, 32'hFFF0_0004, 32'hFFFF_FFFF, 32'h3000_0000,
      32'h0000_0020, 32'h7000_0000, 32'h0000_0010, 32'h8000_4028,
      32'h0000_4108, 32'hFFFF_FFFF};
   logic [7:0]  bb[6] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h00};
   ntbrt_dest_t bd[6] = '{NTBRT_TO_SELF, NTBRT_TO_SELF, NTBRT_TO_DOWN,
      NTBRT_TO_DOWN, NTBRT_TO_UP, NTBRT_TO_UP};
   logic [63:0] ma[7] = '{64'h8000_0000, 64'h80FF_FFFF, 64'h8100_0000,
      64'h7FFF_FFFF, 64'h9003_FFFC, 64'h9004_0000, 64'h1_8000_0000};
   ntbrt_dest_t md[7] = '{NTBRT_TO_DOWN, NTBRT_TO_DOWN, NTBRT_TO_UP,
      NTBRT_TO_UP, NTBRT_TO_SELF, NTBRT_TO_UP, NTBRT_TO_UP};
   logic [19:0] off;  // random offset inside the 1 MB window
   logic [2:0]  fn;   // random function bits

   always #2 clock = ~clock;

   ntbrt_top #(.PORT_NUM(5'h03)) dut (.clock(clock), .rst(rst), .ce(ce),
      .cfgWe(cfgWe), .cfgRe(cfgRe), .cfgAddr(cfgAddr),
      .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .tlpValid(tlpValid),
      .tlpReady(tlpReady), .tlpKind(tlpKind), .tlpAtPort(tlpAtPort),
      .tlpAddr(tlpAddr), .tlpBus(tlpBus), .tlpReqId(tlpReqId),
      .outValid(outValid), .outReady(outReady), .outDest(outDest),
      .outAddr(outAddr), .outIs64(outIs64), .outReqId(outReqId),
      .outCplId(outCplId), .outIdx(outIdx));
   ntbrt_sink sink (.clock(clock), .rst(rst), .slow(slow),
      .outValid(outValid), .outReady(outReady));

   task automatic fail(input string m);
      errors++;
      $display("MISMATCH t=%0t %s", $time, m);
   endtask
   task automatic checkBit(input logic v, input logic e);
      testsRun++;
      if (v !== e) fail("flag after reset");
   endtask
   task automatic checkWord(input logic [31:0] v, input logic [31:0] e);
      testsRun++;
      if (v !== e) fail($sformatf("read %h want %h", v, e));
   endtask
   task automatic checkTlp(input ntbrt_exp_t e);
      testsRun++;
      if (outDest !== e.dest || (e.full && (outAddr !== e.addr ||
          outReqId !== e.rid || outIdx !== e.idx || outCplId !== e.cid ||
          outIs64 !== (e.addr[63:32] != 32'h0000_0000))))
         fail($sformatf("dest %0d addr %h id %h", outDest, outAddr,
                        outReqId));
   endtask
   function automatic ntbrt_exp_t mk(ntbrt_dest_t d, logic f,
      logic [63:0] a, logic [15:0] r, logic [4:0] i, logic [15:0] c);
      mk = '{d, f, a, r, i, c};
   endfunction
   task automatic cfgWrite(input logic [11:0] a, input logic [31:0] d);
      cfgAddr = a; cfgWdata = d; cfgWe = 1'b1;
      @(posedge clock); #1;
      cfgWe = 1'b0;
      @(posedge clock); #1;
   endtask
   task automatic cfgRead(input logic [11:0] a, input logic [31:0] e);
      rdQ.push_back(e);
      cfgAddr = a; cfgRe = 1'b1;
      @(posedge clock); #1;
      cfgRe = 1'b0;
      @(posedge clock); #1;
   endtask
   // header held until a ready edge; valid stays up for the next one
   task automatic send(input ntbrt_kind_t k, input logic at,
      input logic [63:0] a, input logic [7:0] b, input logic [15:0] r,
      input ntbrt_exp_t e);
      int n;
      logic rdy;
      expQ.push_back(e);
      tlpKind = k; tlpAtPort = at; tlpAddr = a; tlpBus = b; tlpReqId = r;
      if (!tlpValid) tlpValid = 1'b1;
      n = 0;
      do begin
         @(negedge clock); rdy = tlpReady;
         @(posedge clock); n++;
      end while (!rdy && n < 50);
      if (!rdy) fail("header not taken");
      #1;
   endtask
   task automatic idle();
      tlpValid = 1'b0;
      @(posedge clock); #1;
   endtask
   task automatic completeRun();
      $display("comparisons %0d mismatches %0d", testsRun, errors);
      if (errors == 0 && testsRun > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // monitor: results are settled by the falling edge
   always @(posedge clock) rdSeen <= !rst && ce && cfgRe;
   always @(negedge clock) begin
      if (!rst && outValid === 1'b1 && outReady === 1'b1) begin
         if (expQ.size() == 0) fail("unexpected decision");
         else checkTlp(expQ.pop_front());
      end
      if (rdSeen) checkWord(cfgRdata, rdQ.pop_front());
   end

   initial begin
      #20000;
      fail("watchdog");
      completeRun();
   end

   initial begin
      int n;
      rst = 1'b1; ce = 1'b1; cfgWe = 1'b0; cfgRe = 1'b0; slow = 1'b0;
      cfgAddr = 12'h000; cfgWdata = 32'h0000_0000; tlpValid = 1'b0;
      tlpKind = NTBRT_KIND_MEM; tlpAtPort = 1'b0; tlpAddr = 64'h0;
      tlpBus = 8'h00; tlpReqId = 16'h0000;
      void'($urandom(32'h6935));
      repeat (4) @(posedge clock);
      #1 rst = 1'b0;
      checkBit(outValid, 1'b0);
      checkBit(tlpReady, 1'b1);
      for (int i = 0; i < 17; i++) cfgWrite(wa[i], wd[i]);
      cfgRead(12'h018, 32'h0005_0201);
      cfgRead(12'h100, 32'hFFF0_0000);
      cfgRead(12'h208, 32'h8000_4028);
      cfgRead(12'h300, 32'h0000_0000);
      slow = 1'b1; // stalled consumer, headers back to back
      for (int i = 0; i < 6; i++) begin
         send(NTBRT_KIND_CPL, 1'b0, 64'h0, bb[i], 16'h4321,
              mk(bd[i], 1'b1, 64'h0, 16'h4321, 5'h00, 16'h0000));
         send(NTBRT_KIND_CFG, 1'b0, 64'h0, bb[i], 16'h4321,
              mk(bd[i], 1'b1, 64'h0, 16'h4321, 5'h00, 16'h0000));
      end
      for (int i = 0; i < 7; i++)
         send(NTBRT_KIND_MEM, 1'b0, ma[i], 8'h00, 16'h4321,
              mk(md[i], 1'b1, ma[i], 16'h4321, 5'h00, 16'h0000));
      send(NTBRT_KIND_IO, 1'b0, 64'h8000_0010, 8'h00, 16'h4321,
           mk(NTBRT_TO_DOWN, 1'b1, 64'h8000_0010, 16'h4321, 5'h00,
              16'h0000));
      slow = 1'b0;
      send(NTBRT_KIND_MEM, 1'b1, 64'h5F00_0080, 8'h00, {8'h40, 5'h05, 3'h6},
           mk(NTBRT_TO_CROSS, 1'b1, 64'h2750_0080, {8'h02, 5'h02, 3'h6},
              5'h02, 16'h0000));
      for (int i = 0; i < 8; i++) begin
         off = 20'($urandom);
         fn = 3'($urandom);
         send(NTBRT_KIND_MEM, 1'b1, {32'h0, 12'h5F0, off}, 8'h00,
              {8'h40, 5'h05, fn}, mk(NTBRT_TO_CROSS, 1'b1,
              {32'h0, 12'h275, off}, {8'h02, 5'h02, fn}, 5'h02,
              16'h0000));
      end
      send(NTBRT_KIND_MEM, 1'b1, 64'h10_7000_1234, 8'h00, 16'h4029,
           mk(NTBRT_TO_CROSS, 1'b1, 64'h20_3000_1234, 16'h0211, 5'h02,
              16'h0000));
      send(NTBRT_KIND_MEM, 1'b1, 64'h5F00_0000, 8'h00, {8'h41, 5'h01, 3'h0},
           mk(NTBRT_TO_UR, 1'b0, 64'h0, 16'h0, 5'h00, 16'h0));
      send(NTBRT_KIND_MEM, 1'b1, 64'h5F00_0000, 8'h00, 16'h3300,
           mk(NTBRT_TO_UR, 1'b0, 64'h0, 16'h0, 5'h00, 16'h0));
      send(NTBRT_KIND_MEM, 1'b1, 64'h5F10_0000, 8'h00, 16'h4028,
           mk(NTBRT_TO_UR, 1'b0, 64'h0, 16'h0, 5'h00, 16'h0));
      send(NTBRT_KIND_MEM, 1'b1, 64'h6000_0010, 8'h00, 16'h4028,
           mk(NTBRT_TO_UR, 1'b0, 64'h0, 16'h0, 5'h00, 16'h0));
      send(NTBRT_KIND_CPL, 1'b1, 64'h0, 8'h02, {8'h02, 5'h02, 3'h6},
           mk(NTBRT_TO_CROSS, 1'b1, 64'h0, {8'h40, 5'h05, 3'h6}, 5'h02,
              {8'h02, 5'h03, 3'h0}));
      send(NTBRT_KIND_CPL, 1'b1, 64'h0, 8'h02, {8'h02, 5'h03, 3'h0},
           mk(NTBRT_TO_UNEXP, 1'b0, 64'h0, 16'h0, 5'h00, 16'h0));
      idle();
      n = 0;
      while (expQ.size() != 0 && n < 200) begin
         @(posedge clock); n++;
      end
      #1;
      cfgWrite(12'h110, 32'h1230_0000);
      send(NTBRT_KIND_MEM, 1'b1, 64'h5F00_0040, 8'h00, {8'h40, 5'h05, 3'h2},
           mk(NTBRT_TO_CROSS, 1'b1, 64'h1230_0040, {8'h02, 5'h02, 3'h2},
              5'h02, 16'h0000));
      idle();
      n = 0;
      while ((expQ.size() != 0 || outValid) && n < 200) begin
         @(posedge clock); n++;
      end
      if (expQ.size() != 0) fail("decisions missing");
      // status holds index and outcome of the last header taken
      cfgRead(12'h134, {24'h00_0000, 5'h02, NTBRT_TO_CROSS});
      // a write while the enable is low must leave the word alone
      ce = 1'b0;
      cfgWrite(12'h004, 32'h0000_0000);
      ce = 1'b1;
      cfgRead(12'h004, 32'h0000_0007);
      completeRun();
   end
endmodule
